/* rtl/pmc_defs.vh */
// Offsets, field positions and timing counts of the power-management block
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH
`define PMC_OFS_PMCTRL     8'h84
`define PMC_OFS_BYTE_TEST  8'h64
`define PMC_OFS_EVENTS     8'hc0
`define PMC_BIT_STATE_HI   13
`define PMC_BIT_STATE_LO   12
`define PMC_BIT_PHY_RESET_REQUEST    10
`define PMC_BIT_WF_EN      9
`define PMC_BIT_ENERGY_DETECT_ENABLE      8
`define PMC_BIT_DRIVE      6
`define PMC_BIT_CAUSE_HI   5
`define PMC_BIT_CAUSE_LO   4
`define PMC_BIT_PULSE      3
`define PMC_BIT_POL        2
`define PMC_BIT_OUT_EN     1
`define PMC_BIT_READY      0
`define PMC_STATE_FULL     2'h0
`define PMC_STATE_WAKE     2'h1
`define PMC_STATE_ENERGY   2'h2
`define PMC_CLK_HZ         10000000
`define PMC_PHY_RESET_REQUEST_US     100
`define PMC_PULSE_MS       50
`define PMC_READY_CYC      16
`define PMC_PHY_RESET_REQUEST_CYC    ((`PMC_PHY_RESET_REQUEST_US * (`PMC_CLK_HZ / 1000000)))
`define PMC_PULSE_CYC      ((`PMC_PULSE_MS * (`PMC_CLK_HZ / 1000)))
`endif

/* rtl/pmc_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pmc_sync (
   input  wire clk_sys_i,
   input  wire sys_rst_i,
   input  wire async_i,
   output reg  sync_o
);
   reg [2:0] stage_r;
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         stage_r <= 3'h0;
         sync_o  <= 1'b0;
      end else begin
         stage_r <= {stage_r[1:0], async_i};
         if (stage_r[2] == stage_r[1])
            sync_o <= stage_r[1];
      end
   end
endmodule // pmc_sync

/* rtl/pmc_timer.v */
// Down counter that holds a level for a set number of cycles
`timescale 1ns/1ns
module pmc_timer #(
   parameter WIDTH = 24
) (
   input  wire             clk_sys_i,
   input  wire             sys_rst_i,
   input  wire             start_i,
   input  wire             abort_i,
   input  wire [WIDTH-1:0] count_i,
   output wire             busy_o
);
   reg [WIDTH-1:0] cnt_r;
   always @(posedge clk_sys_i) begin
      if (sys_rst_i || abort_i)
         cnt_r <= {WIDTH{1'b0}};
      else if (start_i)
         cnt_r <= count_i;
      else if (cnt_r != {WIDTH{1'b0}})
         cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
   end
   assign busy_o = (cnt_r != {WIDTH{1'b0}});
endmodule // pmc_timer

/* rtl/pmc_power_ctrl.v */
// Power-management control register with wake output and PHY reset timer
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "pmc_defs.vh"
module pmc_power_ctrl #(
   parameter PHY_RESET_REQUEST_CYC = `PMC_PHY_RESET_REQUEST_CYC,
   parameter PULSE_CYC   = `PMC_PULSE_CYC,
   parameter READY_CYC   = `PMC_READY_CYC
) (
   input  wire        clk_sys_i,
   input  wire        sys_rst_i,
   input  wire        hsel_i,
   input  wire [7:0]  haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output reg  [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   input  wire        wake_frame_event_i,
   input  wire        energy_event_i,
   output wire [1:0]  power_state_o,
   output wire        wake_frame_detect_en_o,
   output wire        phy_reset_o,
   output wire        wake_interrupt_flag_o,
   output reg         wake_event_output_o,
   output reg         wake_event_output_oe_n_o
);
   ////////////////////////////////////////////////////////////////////////
   localparam ST_READY   = 2'h0;
   localparam ST_REDUCED = 2'h1;
   localparam ST_SETTLE  = 2'h2;

   function is_addr;
      input [7:0] a;
      input [7:0] ofs;
      begin
         is_addr = (a[7:2] == ofs[7:2]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   reg        wr_ph_r;
   reg        rd_ph_r;
   reg [7:0]  addr_r;
   wire       take = hsel_i && hready_i && htrans_i[1];

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_ph_r <= 1'b0;
         rd_ph_r <= 1'b0;
         addr_r  <= 8'h00;
      end else if (hready_i) begin
         wr_ph_r <= take && hwrite_i;
         rd_ph_r <= take && !hwrite_i;
         addr_r  <= haddr_i;
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Event inputs come from other logic domains
   wire wf_sync;
   wire ed_sync;

   pmc_sync u_sync_wf (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (wake_frame_event_i),
      .sync_o    (wf_sync)
   );

   pmc_sync u_sync_ed (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (energy_event_i),
      .sync_o    (ed_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register fields
   reg  [1:0] state_sel_r;
   reg        wf_en_r;
   reg        energy_detect_enable_r;
   reg        drive_r;
   reg  [1:0] cause_r;
   reg        pulse_sel_r;
   reg        pol_r;
   reg        out_en_r;
   reg  [1:0] seq_r;
   reg        read_seen_r;
   reg        wake_act_r;
   reg  [4:0] settle_r;

   wire ready     = (seq_r == ST_READY);
   wire wr_pm     = wr_ph_r && is_addr(addr_r, `PMC_OFS_PMCTRL);
   wire wr_bt     = wr_ph_r && is_addr(addr_r, `PMC_OFS_BYTE_TEST);
   wire wr_ok     = wr_pm && read_seen_r && ready;
   wire wf_hit    = wf_sync && wf_en_r;
   wire ed_hit    = ed_sync && energy_detect_enable_r;
   wire ev_hit    = wf_hit || ed_hit;
   wire phy_busy;

   ////////////////////////////////////////////////////////////////////////
   // PHY reset hold
   wire phy_start = wr_ok && hwdata_i[`PMC_BIT_PHY_RESET_REQUEST] && !phy_busy;

   pmc_timer #(
      .WIDTH (24)
   ) u_phy_timer (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (phy_start),
      .abort_i   (1'b0),
      .count_i   (PHY_RESET_REQUEST_CYC[23:0]),
      .busy_o    (phy_busy)
   );

   assign phy_reset_o = phy_busy;

   ////////////////////////////////////////////////////////////////////////
   // Wake pulse timer
   wire pulse_busy;
   wire out_kill;
   wire pulse_start = ev_hit && !wake_act_r;

   pmc_timer #(
      .WIDTH (24)
   ) u_pulse_timer (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (pulse_start),
      .abort_i   (out_kill),
      .count_i   (PULSE_CYC[23:0]),
      .busy_o    (pulse_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Cause clear: set wins over clear
   wire [1:0] clr_req  = (wr_ok && !wf_sync && !ed_sync) ?
                         hwdata_i[`PMC_BIT_CAUSE_HI:`PMC_BIT_CAUSE_LO] :
                         2'h0;
   wire [1:0] cause_set = {wf_hit, ed_hit};
   wire [1:0] cause_nxt = (cause_r & ~clr_req) | cause_set;

   wire en_off = wr_ok &&
                 ((wf_en_r && !hwdata_i[`PMC_BIT_WF_EN]) ||
                  (energy_detect_enable_r && !hwdata_i[`PMC_BIT_ENERGY_DETECT_ENABLE]));
   assign out_kill = (cause_nxt == 2'h0 && cause_r != 2'h0) ||
                     en_off;

   ////////////////////////////////////////////////////////////////////////
   // Control register and sequencing
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         state_sel_r <= `PMC_STATE_FULL;
         wf_en_r     <= 1'b0;
         energy_detect_enable_r     <= 1'b0;
         drive_r     <= 1'b0;
         cause_r     <= 2'h0;
         pulse_sel_r <= 1'b0;
         pol_r       <= 1'b0;
         out_en_r    <= 1'b0;
         seq_r       <= ST_SETTLE;
         read_seen_r <= 1'b0;
         wake_act_r  <= 1'b0;
         settle_r    <= READY_CYC[4:0];
      end else begin
         cause_r <= cause_nxt;
         if (ev_hit)
            wake_act_r <= 1'b1;
         else if (out_kill)
            wake_act_r <= 1'b0;
         if (rd_ph_r)
            read_seen_r <= 1'b1;
         if (wr_ok) begin
            if (hwdata_i[`PMC_BIT_STATE_HI:`PMC_BIT_STATE_LO] != 2'h3)
               state_sel_r <= hwdata_i[`PMC_BIT_STATE_HI:`PMC_BIT_STATE_LO];
            wf_en_r     <= hwdata_i[`PMC_BIT_WF_EN];
            energy_detect_enable_r     <= hwdata_i[`PMC_BIT_ENERGY_DETECT_ENABLE];
            drive_r     <= hwdata_i[`PMC_BIT_DRIVE];
            pulse_sel_r <= hwdata_i[`PMC_BIT_PULSE];
            pol_r       <= hwdata_i[`PMC_BIT_POL];
            out_en_r    <= hwdata_i[`PMC_BIT_OUT_EN];
         end
         case (seq_r)
            ST_READY: begin
               if (wr_ok && hwdata_i[`PMC_BIT_STATE_HI:`PMC_BIT_STATE_LO]
                            != `PMC_STATE_FULL &&
                   hwdata_i[`PMC_BIT_STATE_HI:`PMC_BIT_STATE_LO] != 2'h3)
                  seq_r <= ST_REDUCED;
            end
            ST_REDUCED: begin
               if (wr_bt || ev_hit) begin
                  seq_r       <= ST_SETTLE;
                  settle_r    <= READY_CYC[4:0];
                  state_sel_r <= `PMC_STATE_FULL;
                  read_seen_r <= 1'b0;
               end
            end
            ST_SETTLE: begin
               if (settle_r == 5'h00)
                  seq_r <= ST_READY;
               else
                  settle_r <= settle_r - 5'h01;
            end
            default: seq_r <= ST_SETTLE;
         endcase
      end
   end

   assign power_state_o          = state_sel_r;
   assign wake_frame_detect_en_o = (state_sel_r == `PMC_STATE_WAKE);
   assign wake_interrupt_flag_o  = wake_act_r;

   ////////////////////////////////////////////////////////////////////////
   // Wake pin drive
   wire active = out_en_r && wake_act_r &&
                 (!pulse_sel_r || pulse_busy);

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wake_event_output_o      <= 1'b1;
         wake_event_output_oe_n_o <= 1'b1;
      end else if (!drive_r) begin
         wake_event_output_o      <= 1'b0;
         wake_event_output_oe_n_o <= !active;
      end else begin
         wake_event_output_o      <= active ? pol_r : !pol_r;
         wake_event_output_oe_n_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data
   always @(posedge clk_sys_i) begin
      if (sys_rst_i)
         hrdata_o <= 32'h00000000;
      else if (take && !hwrite_i) begin
         if (is_addr(haddr_i, `PMC_OFS_PMCTRL))
            hrdata_o <= {18'h00000, state_sel_r, 1'b0, phy_busy, wf_en_r,
                         energy_detect_enable_r, 1'b0, drive_r, cause_r, pulse_sel_r,
                         pol_r, out_en_r, ready};
         else if (is_addr(haddr_i, `PMC_OFS_EVENTS))
            hrdata_o <= {30'h00000000, wf_sync, ed_sync};
         else
            hrdata_o <= 32'h00000000;
      end
   end
endmodule // pmc_power_ctrl

/* tb/pmc_power_ctrl_assertions.sv */
// Port-level checks of the power-management control block
`timescale 1ns/1ns
module pmc_power_ctrl_assertions #(
   parameter PHY_RESET_REQUEST_CYC = 1000
) (
   input wire        clk_sys_i,
   input wire        sys_rst_i,
   input wire        hsel_i,
   input wire [1:0]  htrans_i,
   input wire        hwrite_i,
   input wire [31:0] hrdata_o,
   input wire        hreadyout_o,
   input wire        hresp_o,
   input wire [1:0]  power_state_o,
   input wire        wake_frame_detect_en_o,
   input wire        phy_reset_o,
   input wire        wake_interrupt_flag_o,
   input wire        wake_event_output_oe_n_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   reg [15:0] phy_cnt_r;
   // Cycles the PHY reset has been held
   always @(posedge clk_sys_i) begin
      if (sys_rst_i || !phy_reset_o)
         phy_cnt_r <= 16'h0;
      else
         phy_cnt_r <= phy_cnt_r + 16'h1;
   end
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not zero-wait okay");
   a_state_legal: assert property (power_state_o != 2'h3)
      else $error("reserved power state reached");
   a_detect_state: assert property
      (wake_frame_detect_en_o == (power_state_o == 2'h1))
      else $error("detect enable does not follow state");
   a_phy_hold_min: assert property
      ($fell(phy_reset_o) |-> phy_cnt_r >= PHY_RESET_REQUEST_CYC)
      else $error("phy reset released too early");
   a_phy_by_write: assert property
      ($rose(phy_reset_o) |-> $past(hwrite_i) || $past(hwrite_i, 2))
      else $error("phy reset without a write");
   a_flag_by_write: assert property
      ($fell(wake_interrupt_flag_o) |-> $past(hwrite_i) || $past(hwrite_i, 2))
      else $error("wake flag cleared without a write");
   a_rdata_hold: assert property
      (!(hsel_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
      else $error("read data changed without a read");
   a_rst_quiet: assert property ($past(sys_rst_i) |->
      wake_event_output_oe_n_o && !phy_reset_o && power_state_o == 2'h0)
      else $error("outputs not idle after reset");
   a_state_by_write: assert property
      ($changed(power_state_o) && power_state_o != 2'h0
       |-> $past(hwrite_i) || $past(hwrite_i, 2))
      else $error("reduced state entered without a write");
endmodule // pmc_power_ctrl_assertions

bind pmc_power_ctrl pmc_power_ctrl_assertions #(
   .PHY_RESET_REQUEST_CYC(PHY_RESET_REQUEST_CYC)
) u_chk (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .power_state_o(power_state_o),
   .wake_frame_detect_en_o(wake_frame_detect_en_o),
   .phy_reset_o(phy_reset_o),
   .wake_interrupt_flag_o(wake_interrupt_flag_o),
   .wake_event_output_oe_n_o(wake_event_output_oe_n_o)
);

/* tb/pmc_host.sv */
// Host bus master issuing single word transfers
`timescale 1ns/1ns
module pmc_host (
   input  wire        clk_sys_i,
   input  wire        hready_i,
   input  wire [31:0] hrdata_i,
   output reg         hsel_o,
   output reg  [7:0]  haddr_o,
   output reg  [1:0]  htrans_o,
   output reg         hwrite_o,
   output reg  [31:0] hwdata_o
);
   initial begin
      hsel_o = 1'b0;
      haddr_o = 8'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hwdata_o = 32'h0;
   end
   task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
      begin
         @(posedge clk_sys_i);
         hsel_o <= 1'b1;
         haddr_o <= a;
         htrans_o <= 2'h2;
         hwrite_o <= w;
         // Stale data bus never shows the last word
         hwdata_o <= ~hwdata_o;
         @(posedge clk_sys_i);
         while (!hready_i) @(posedge clk_sys_i);
         hsel_o <= 1'b0;
         htrans_o <= 2'h0;
         hwdata_o <= d;
         @(posedge clk_sys_i);
         while (!hready_i) @(posedge clk_sys_i);
         q = hrdata_i;
      end
   endtask
endmodule // pmc_host

/* tb/power_mgmt_control_tb.sv */
// Self-checking bench of the power-management control block
`timescale 1ns/1ns
`include "pmc_defs.vh"
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
module power_mgmt_control_tb;
   localparam [7:0] PM = `PMC_OFS_PMCTRL;
   localparam [7:0] BT = `PMC_OFS_BYTE_TEST;
   localparam       PLS = 40;
   reg         clk_sys_i;
   reg         sys_rst_i;
   reg         ev_f;
   reg         ev_e;
   reg  [31:0] q;
   wire        hsel, hwrite, hrdy, hresp, det, phy, flag, pin, oe_n;
   wire [7:0]  haddr;
   wire [1:0]  htrans, st;
   wire [31:0] hwdata, hrdata;
   integer     error_cnt;
   integer     checked;
   integer     i;
   pmc_host host (.clk_sys_i(clk_sys_i), .hready_i(hrdy), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hwdata_o(hwdata));
   pmc_power_ctrl #(.PHY_RESET_REQUEST_CYC(20), .PULSE_CYC(PLS), .READY_CYC(16)) dut (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
      .hreadyout_o(hrdy), .hresp_o(hresp), .wake_frame_event_i(ev_f),
      .energy_event_i(ev_e), .power_state_o(st),
      .wake_frame_detect_en_o(det), .phy_reset_o(phy),
      .wake_interrupt_flag_o(flag), .wake_event_output_o(pin),
      .wake_event_output_oe_n_o(oe_n));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string n, input [31:0] e, input [31:0] a);
      begin
         checked = checked + 1;
         if (a !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, a);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task rd(input [7:0] a);
      host.xfer(1'b0, a, 32'h0, q);
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_sys_i);
         #1;
      end
   endtask
   task rdy;
      begin
         q = 32'h0;
         for (i = 0; i < 60 && q[0] !== 1'b1; i = i + 1)
            rd(PM);
         `CHK("ready", 1, q[0]);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", checked, error_cnt);
         if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      error_cnt = error_cnt + 1;
      finish_test;
   end
   initial begin
      error_cnt = 0;
      checked = 0;
      sys_rst_i = 1'b1;
      ev_f = 1'b0;
      ev_e = 1'b0;
      tick(2);
      sys_rst_i <= 1'b0;
      tick(1);
      `CHK("oe_n reset", 1, oe_n);
      // Ready by now, but no read yet: this write must be ignored
      tick(30);
      wr(PM, 32'h346);
      rdy;
      `CHK("reset value", 32'h1, q);
      rd(8'h10);
      `CHK("unmapped", 0, q);
      wr(PM, 32'h346);
      rd(PM);
      `CHK("config", 32'h347, q);
      `CHK("pin idle", 0, {oe_n, pin});
      wr(PM, 32'h3346);
      tick(2);
      `CHK("state 11", 0, st);
      wr(PM, 32'h746);
      tick(2);
      `CHK("phy on", 1, phy);
      // Second request while held must not restart the hold
      wr(PM, 32'h746);
      tick(2);
      `CHK("phy ignore", 1, phy);
      for (i = 0; i < 100 && phy === 1'b1; i = i + 1)
         tick(1);
      `CHK("phy not restarted", 1, i < 16);
      rd(PM);
      `CHK("phy self clear", 0, q[10]);
      wr(PM, 32'h1346);
      tick(2);
      `CHK("wake state", 1, st);
      `CHK("detect en", 1, det);
      @(posedge clk_sys_i) ev_e <= 1'b1;
      tick(12);
      `CHK("state back", 0, st);
      `CHK("flag energy", 1, flag);
      `CHK("pin level", 1, {oe_n, pin});
      rdy;
      `CHK("cause energy", 1, q[5:4]);
      wr(PM, 32'h356);
      rd(PM);
      `CHK("cause held", 1, q[5:4]);
      @(posedge clk_sys_i) ev_e <= 1'b0;
      tick(8);
      wr(PM, 32'h356);
      tick(2);
      `CHK("flag clear", 0, flag);
      `CHK("pin off", 0, {oe_n, pin});
      rd(PM);
      `CHK("cause none", 0, q[5:4]);
      wr(PM, 32'h2346);
      tick(2);
      `CHK("energy state", 2, st);
      wr(BT, 32'h0);
      tick(2);
      `CHK("byte test wake", 0, st);
      rdy;
      wr(PM, 32'h1200);
      tick(2);
      @(posedge clk_sys_i) ev_f <= 1'b1;
      tick(12);
      `CHK("flag frame", 1, flag);
      `CHK("pin gated", 1, oe_n);
      rdy;
      `CHK("cause frame", 2, q[5:4]);
      @(posedge clk_sys_i) ev_f <= 1'b0;
      tick(8);
      wr(PM, 32'h230);
      wr(PM, 32'h130e);
      tick(2);
      @(posedge clk_sys_i) {ev_f, ev_e} <= 2'h3;
      tick(10);
      `CHK("open drain on", 0, {oe_n, pin});
      tick(PLS + 10);
      `CHK("pulse ended", 1, oe_n);
      `CHK("flag stays", 1, flag);
      rdy;
      `CHK("cause multi", 3, q[5:4]);
      finish_test;
   end
endmodule // power_mgmt_control_tb
